/* File: test/beid_chk.sv */
// Checker for the identify answer and register read values.
// Assumes it is bound into beid_core on pclk.
`default_nettype none
module beid_chk
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Identify and command
	input wire beid_pkg::beid_ident_req_s ident_req,
	input wire beid_pkg::beid_ident_ans_s ident_ans,
	input wire logic err_irq_req,
	input wire logic [15:0] interrupt_command_dest
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hit;
	logic rd;
	logic dest_wr;
	// Destination hit, read access and destination write
	assign hit = ident_req.valid & |(ident_req.master_id & interrupt_command_dest);
	assign rd = psel & penable & !pwrite;
	assign dest_wr = psel & penable & pwrite & (paddr == beid_pkg::OFF_IRQ_TARGET);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_answer_pending: assert property (ident_ans.respond |-> $past(err_irq_req))
		else $error("answer with no request");
	chk_answer_match: assert property (ident_ans.respond |-> $past(hit))
		else $error("answer with no match");
	chk_dest_load: assert property (hit
		|=> interrupt_command_dest == $past(ident_req.master_id))
		else $error("destination not loaded");
	chk_vector_form: assert property (ident_ans.vector_word[31:14] == 18'h0
		&& ident_ans.vector_word[1:0] == 2'h0)
		else $error("vector out of field");
	chk_one_answer: assert property (ident_ans.respond |=> !ident_ans.respond)
		else $error("serviced request answered");
	chk_dest_read: assert property (rd && paddr == beid_pkg::OFF_IRQ_TARGET
		|-> prdata == {16'h0000, $past(interrupt_command_dest)})
		else $error("destination read wrong");
	chk_ctl_zero: assert property (rd && paddr == beid_pkg::OFF_ERROR_IRQ_CONTROL
		|-> prdata[1:0] == 2'h0 && prdata[15:14] == 2'h0 && prdata[31:22] == 10'h000)
		else $error("reserved bits set");
	chk_dest_hold: assert property ($changed(interrupt_command_dest) |-> $past(hit | dest_wr))
		else $error("destination changed");
endmodule : beid_chk
bind beid_core beid_chk beid_chk_i
(
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pslverr(pslverr),
	.ident_req(ident_req),
	.ident_ans(ident_ans),
	.err_irq_req(err_irq_req),
	.interrupt_command_dest(interrupt_command_dest)
);
`default_nettype wire

/* File: test/beid_node.sv */
// Model of a remote node that issues identify commands.
// Assumes the answer comes one cycle after the request.
`default_nettype none
module beid_node
(
	// Clock
	input wire logic pclk,
	// Identify and command
	output beid_pkg::beid_ident_req_s ident_req,
	input wire beid_pkg::beid_ident_ans_s ident_ans,
	input wire logic [15:0] interrupt_command_dest,
	output logic targeted
);
	timeunit 1ns;
	timeprecision 1ps;
	// This node acts only on commands that name it
	assign targeted = interrupt_command_dest[2];
	initial ident_req = '0;
	// One-cycle request; fields turn to garbage once released
	task ident(input logic [15:0] i, input logic [3:0] l, output logic r, output logic [31:0] v);
		@(posedge pclk);
		ident_req <= {1'b1, i, l};
		@(posedge pclk);
		ident_req <= {1'b0, ~i, ~l};
		@(negedge pclk);
		r = ident_ans.respond;
		v = ident_ans.vector_word;
	endtask : ident
endmodule : beid_node
`default_nettype wire

/* File: test/testbench.sv */
// Register and identify tests for beid_core.
// Assumes beid_node as far side and the bound checker.
`default_nettype none
`define CHK(g, x) check(32'(g), 32'(x))
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic err_irq_req, targeted, e, r;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, bus_error_flags_reg = 32'h0, q;
	logic [15:0] interrupt_command_dest;
	int err_total = 0, n_compared = 0, cyc = 0, n_wait = 0;
	beid_pkg::beid_ident_req_s ident_req;
	beid_pkg::beid_ident_ans_s ident_ans;
	beid_core beid_core_i
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.bus_error_flags_reg(bus_error_flags_reg),
		.ident_req(ident_req),
		.ident_ans(ident_ans),
		.err_irq_req(err_irq_req),
		.interrupt_command_dest(interrupt_command_dest)
	);
	beid_node beid_node_i
	(
		.pclk(pclk),
		.ident_req(ident_req),
		.ident_ans(ident_ans),
		.interrupt_command_dest(interrupt_command_dest),
		.targeted(targeted)
	);
	// 4 ns clock and a hang ceiling
	initial forever #2 pclk = ~pclk;
	always @(posedge pclk)
		if (++cyc == 2000)
		begin
			err_total++;
			results();
		end
	task check(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x)
		begin
			err_total++;
			$display("[FAIL] t=%0t got %0h exp %0h", $time, g, x);
		end
	endtask : check
	// Setup, then access held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n_wait = 0;
		do
		begin
			@(posedge pclk);
			n_wait++;
		end
		while (pready !== 1'b1);
		{q, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		`CHK(n_wait, 1);
		`CHK(q, x);
		`CHK(e, xe);
	endtask : rd
	task idn(input logic [15:0] i, input logic [3:0] l, input logic xr, input logic [31:0] xv);
		beid_node_i.ident(i, l, r, q);
		`CHK(r, xr);
		`CHK(q, xv);
	endtask : idn
	// Request level, looked at once settled
	task irq(input logic x);
		@(negedge pclk);
		`CHK(err_irq_req, x);
		@(posedge pclk);
	endtask : irq
	task results();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h10, 32'h0, 1'b0);
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		rd(8'h10, 32'h0000FFFF, 1'b0);
		apb(1'b1, 8'h0C, 32'hFFFFFFFF);
		rd(8'h0C, 32'h001F3FFC, 1'b0);
		irq(1'b1);
		rd(8'h20, 32'h0, 1'b1);
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		rd(8'h14, 32'h0, 1'b0);
		$display("register test done");
		idn(16'h0004, 4'h2, 1'b1, 32'h00003FFC);
		`CHK(interrupt_command_dest, 16'h0004);
		`CHK(targeted, 1'b1);
		idn(16'h0004, 4'h2, 1'b0, 32'h0);
		rd(8'h08, 32'h00000003, 1'b0);
		rd(8'h0C, 32'h003F3FFC, 1'b0);
		apb(1'b1, 8'h0C, 32'h00003FFC);
		irq(1'b0);
		apb(1'b1, 8'h0C, 32'h00113FFC);
		idn(16'h0008, 4'h1, 1'b0, 32'h0);
		`CHK(interrupt_command_dest, 16'h0004);
		idn(16'h0004, 4'h2, 1'b0, 32'h0);
		idn(16'h0004, 4'h1, 1'b1, 32'h00003FFC);
		$display("identify test done");
		apb(1'b1, 8'h0C, 32'h0);
		bus_error_flags_reg <= 32'h1;
		irq(1'b0);
		apb(1'b1, 8'h04, 32'h2);
		rd(8'h04, 32'h00000002, 1'b0);
		for (int i = 0; i < 3; i++)
		begin
			bus_error_flags_reg <= 32'h1 << i;
			irq(1'b1);
		end
		bus_error_flags_reg <= 32'h00010000;
		irq(1'b0);
		apb(1'b1, 8'h04, 32'h1);
		irq(1'b1);
		$display("error request test done");
		// Mid-run reset must clear the destination and the enables
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h10, 32'h0, 1'b0);
		`CHK(targeted, 1'b0);
		rd(8'h04, 32'h0, 1'b0);
		irq(1'b0);
		$display("reset test done");
		results();
	end
endmodule : testbench
`default_nettype wire

/* File: verilog/beid_core.sv */
// Error interrupt request, vector and destination logic with APB registers.
// Assumes bus error flags and identify commands are produced on pclk.
// Assumes the identify valid is a one-cycle pulse with a one-hot decoded master ID,
// and that whoever sets the bus error flags also holds and clears them.
// Unused processor interrupt registers are kept as read-as-zero locations.
`default_nettype none
module beid_core
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bus error flags
	input wire logic [31:0] bus_error_flags_reg,
	// Identify command and answer
	input wire beid_pkg::beid_ident_req_s ident_req,
	output beid_pkg::beid_ident_ans_s ident_ans,
	// Interrupt command
	output logic err_irq_req,
	output logic [15:0] interrupt_command_dest
);
	// Programmed fields of the bus control, control and destination registers, and the serviced mark
	logic [11:0] vector;
	logic [3:0] level_field;
	logic force_bit;
	logic serviced;
	logic [15:0] irq_target;
	logic hard_en;
	logic soft_error_irq_enable;
	// Match results and decoded sources
	logic dest_match;
	logic answer;
	logic hard_hit;
	logic soft_hit;
	// APB decode
	logic wr_en;
	logic rd_setup;
	logic [31:0] next_rdata;
	logic bad_addr;

	// Address decode used by both the write enable and the error answer
	// Keeping it in one place stops the write enable and pslverr from disagreeing
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == beid_pkg::OFF_BUS_CONTROL) || (a == beid_pkg::OFF_ERR_STATUS)
			|| (a == beid_pkg::OFF_ERROR_IRQ_CONTROL) || (a == beid_pkg::OFF_IRQ_TARGET)
			|| (a == beid_pkg::OFF_PROC_IRQ_MASK)
			|| (a == beid_pkg::OFF_FORCED_PROC_IRQ_TARGET)
			|| (a == beid_pkg::OFF_PROC_IRQ_ORIGIN);
	endfunction : addr_mapped

	// pready never drops, so software never stalls here; the cost is that read data
	// must be ready in the access cycle, which the setup capture below provides.
	// Writes to unmapped addresses are dropped.
	// Zero wait states; read data is captured in setup so it comes from a flop
	assign pready = 1'b1;
	assign bad_addr = !addr_mapped(paddr);
	assign pslverr = psel && penable && bad_addr;
	assign wr_en = psel && penable && pwrite && !bad_addr;
	assign rd_setup = psel && !penable && !pwrite;

	// Enabled error sources; the flags are levels, so the request stays up until
	// their owner clears them or software drops the enable.
	// The force bit bypasses the enables so software can test the path alone.
	assign hard_hit = hard_en
		&& (bus_error_flags_reg[beid_pkg::HARD_MSB:beid_pkg::HARD_LSB] != 16'h0000);
	assign soft_hit = soft_error_irq_enable
		&& (bus_error_flags_reg[beid_pkg::SOFT_MSB:0] != 3'h0);
	assign err_irq_req = hard_hit || soft_hit || force_bit;

	// The destination travels with every interrupt command
	// Receivers decide from this field whether the command is theirs
	assign interrupt_command_dest = irq_target;

	// Match logic is kept apart so the identify path can be timed on its own;
	// it sees the live request, so a request that drops cancels the answer.
	beid_ident_match u_match
	(
		.target(irq_target),
		.level_field(level_field),
		.pending(err_irq_req),
		.serviced(serviced),
		.req(ident_req),
		.dest_match(dest_match),
		.answer(answer)
	);

	// Bus control enables; both start off, so no flag can raise a request
	// before software has set up the vector and the destination.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hard_en <= beid_pkg::BUS_CONTROL_RST[0];
			soft_error_irq_enable <= beid_pkg::BUS_CONTROL_RST[1];
		end
		else if (wr_en && paddr == beid_pkg::OFF_BUS_CONTROL)
		begin
			hard_en <= pwdata[beid_pkg::HARD_EN_BIT];
			soft_error_irq_enable <= pwdata[beid_pkg::SOFT_EN_BIT];
		end
	end

	// Vector, level and force fields of the control register
	// Read-only bits such as sent are ignored on write, not stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vector <= beid_pkg::VECTOR_RST;
			level_field <= beid_pkg::LEVEL_RST;
			force_bit <= 1'b0;
		end
		else if (wr_en && paddr == beid_pkg::OFF_ERROR_IRQ_CONTROL)
		begin
			vector <= pwdata[beid_pkg::VEC_MSB:beid_pkg::VEC_LSB];
			level_field <= pwdata[beid_pkg::LEVEL_MSB:beid_pkg::LEVEL_LSB];
			force_bit <= pwdata[beid_pkg::FORCE_BIT];
		end
	end

	// Serviced marks a request already answered; it drops with the request
	// Without this mark every later identify at the same level would be answered
	// again while the flags stay set.
	// The mark is also the sent bit that software reads back.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			serviced <= 1'b0;
		else if (answer)
			serviced <= 1'b1;
		else if (!err_irq_req)
			serviced <= 1'b0;
	end

	// Destination register; a hardware load wins over a same-cycle write
	// Any destination match reloads the field, even when no answer follows.
	// A same-cycle write is lost; software should not rewrite the field while
	// identify traffic is running.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_target <= beid_pkg::TARGET_RST;
		else if (dest_match)
			irq_target <= ident_req.master_id;
		else if (wr_en && paddr == beid_pkg::OFF_IRQ_TARGET)
			irq_target <= pwdata[15:0];
	end

	// Identify answer, one cycle after the command
	// The vector word is zero unless this node answers, so other nodes can
	// share the answer lines by a plain OR.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ident_ans <= '0;
		else
		begin
			ident_ans.respond <= answer;
			ident_ans.vector_word <= answer ? {18'h0, vector, 2'h0} : 32'h00000000;
		end
	end

	// Read mux; everything not listed reads zero
	// Unused registers stay mapped so software probing them sees zero, not an
	// error; only addresses outside the map raise pslverr.
	always_comb
	begin
		next_rdata = 32'h00000000;
		unique case (paddr)
			beid_pkg::OFF_BUS_CONTROL:
			begin
				next_rdata[beid_pkg::HARD_EN_BIT] = hard_en;
				next_rdata[beid_pkg::SOFT_EN_BIT] = soft_error_irq_enable;
			end
			beid_pkg::OFF_ERR_STATUS:
			begin
				next_rdata[0] = err_irq_req;
				next_rdata[1] = serviced;
				next_rdata[2] = hard_hit;
				next_rdata[3] = soft_hit;
			end
			beid_pkg::OFF_ERROR_IRQ_CONTROL:
			begin
				next_rdata[beid_pkg::VEC_MSB:beid_pkg::VEC_LSB] = vector;
				next_rdata[beid_pkg::LEVEL_MSB:beid_pkg::LEVEL_LSB] = level_field;
				next_rdata[beid_pkg::FORCE_BIT] = force_bit;
				next_rdata[beid_pkg::SENT_BIT] = serviced;
			end
			beid_pkg::OFF_IRQ_TARGET:
				next_rdata[15:0] = irq_target;
			default:
				next_rdata = 32'h00000000;
		endcase
	end

	// Read data register
	// Captured only in setup so prdata stays put through the access and after it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd_setup)
			prdata <= next_rdata;
	end
endmodule : beid_core
`default_nettype wire

/* File: verilog/beid_ident_match.sv */
// Destination and level match for an identify command.
// Assumes all inputs are on pclk; purely combinational.
`default_nettype none
module beid_ident_match
(
	// Programmed state
	input wire logic [15:0] target,
	input wire logic [3:0] level_field,
	input wire logic pending,
	input wire logic serviced,
	// Identify command
	input wire beid_pkg::beid_ident_req_s req,
	// Results
	output logic dest_match,
	output logic answer
);
	// Decoded IDs are one-hot, so any common bit is a match
	assign dest_match = req.valid && ((req.master_id & target) != 16'h0000);

	// Answer only with an unserviced request whose level shares a bit with level_field
	assign answer = dest_match && pending && !serviced
		&& ((req.level & level_field) != 4'h0);
endmodule : beid_ident_match
`default_nettype wire

/* File: verilog/beid_pkg.sv */
// Package for the bus error interrupt and destination logic.
// Assumes a 32-bit APB register port and a single 250 MHz bus cycle clock.
`default_nettype none
package beid_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_BUS_CONTROL = 8'h04;
	localparam logic [7:0] OFF_ERR_STATUS = 8'h08;
	localparam logic [7:0] OFF_ERROR_IRQ_CONTROL = 8'h0C;
	localparam logic [7:0] OFF_IRQ_TARGET = 8'h10;
	localparam logic [7:0] OFF_PROC_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFF_FORCED_PROC_IRQ_TARGET = 8'h18;
	localparam logic [7:0] OFF_PROC_IRQ_ORIGIN = 8'h1C;

	// Field positions in error_irq_control_reg
	localparam int VEC_LSB = 2;
	localparam int VEC_MSB = 13;
	localparam int LEVEL_LSB = 16;
	localparam int LEVEL_MSB = 19;
	localparam int FORCE_BIT = 20;
	localparam int SENT_BIT = 21;

	// Field positions in bus_control
	localparam int HARD_EN_BIT = 0;
	localparam int SOFT_EN_BIT = 1;

	// Bus error flag groups: soft errors in the low bits, hard errors high
	localparam int SOFT_MSB = 2;
	localparam int HARD_LSB = 16;
	localparam int HARD_MSB = 31;

	// Reset values
	localparam logic [11:0] VECTOR_RST = 12'h000;
	localparam logic [3:0] LEVEL_RST = 4'h0;
	localparam logic [15:0] TARGET_RST = 16'h0000;
	localparam logic [1:0] BUS_CONTROL_RST = 2'h0;

	// Identify command as seen on the backplane
	typedef struct packed {
		logic valid;
		logic [15:0] master_id;
		logic [3:0] level;
	} beid_ident_req_s;

	// Answer to an identify command
	typedef struct packed {
		logic respond;
		logic [31:0] vector_word;
	} beid_ident_ans_s;
endpackage : beid_pkg
`default_nettype wire
